// ==== hw/negate_file_op_pkg.sv ====
// Purpose: Shared constants and carrier types for the negate / no-op / stack-op execute block
// Assumes: One 25 MHz clock, four clock cycles per instruction cycle
// Notes: Register offsets are byte addresses on a 32-bit APB bus
package exec_pkg;

  // Widths and depths
  localparam int INSTR_W = 16;
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam int STACK_DEPTH = 31;
  localparam int STACK_PTR_W = 5;
  localparam int APB_AW = 8;

  // Opcode fields
  localparam logic [6:0] OPC_NEGATE = 7'h36;
  localparam int OPC_NEGATE_LSB = 9;
  localparam int ACCESS_BIT = 8;
  localparam logic [15:0] OPC_POP = 16'h0006;
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_NOP_ZERO = 16'h0000;
  localparam logic [3:0] OPC_NOP_HIGH = 4'hf;

  // Addressing
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [PC_W-1:0] PUSH_PC_STEP = 21'h000002;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam int FLAGS_W = 5;

  // Register map (byte offsets)
  localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] BANK_OFS = 8'h04;
  localparam logic [APB_AW-1:0] FLAGS_OFS = 8'h08;
  localparam logic [APB_AW-1:0] STACK_OFS = 8'h0c;
  localparam int CTRL_EXT_EN_BIT = 0;

  // Reset values
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 5'h00;

  // Quarter phases of one instruction cycle
  localparam int QUARTERS = 4;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_NEGATE = 3'b001,
    OP_POP = 3'b010,
    OP_PUSH = 3'b011,
    OP_NOP = 3'b100
  } op_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [DADDR_W-1:0] addr;
    logic [7:0] wdata;
  } dmem_req_t;

endpackage

// ==== hw/negate_nop_stack_ops_exec.sv ====
// Purpose: Executes negate-file, no-operation, pop and push instructions of an 8-bit core
// Assumes: Instruction word and data memory are on the same clock; memory read data is combinational
// Notes: One instruction cycle is four clocks: decode, read/push, process/pop, write
//
// What this block does
// - Negate opcode replaces the addressed byte by its two's complement, updating all five flags.
// - The negated result goes back to the same data location, never to W.
// - Access bit clear picks the access bank; set uses the bank select register.
// - Extended set, access bit clear and address up to 5Fh use indexed offset addressing.
// - Pop discards the top return-stack entry in the third quarter; flags untouched.
// - After pop the entry one level below becomes the new top.
// - Push places PC plus 2 on the stack top in the second quarter; flags untouched.
// - Push moves the former top one level down, still reachable later.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module negate_nop_stack_ops_exec (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register bus
  input wire exec_pkg::apb_req_t apb_req_i,
  output exec_pkg::apb_rsp_t apb_rsp_o,
  // Instruction stream
  input wire logic instr_valid_i,
  input wire logic [exec_pkg::INSTR_W-1:0] instr_i,
  input wire logic [exec_pkg::PC_W-1:0] pc_i,
  input wire logic [exec_pkg::DADDR_W-1:0] index_base_i,
  // Data memory
  output exec_pkg::dmem_req_t dmem_req_o,
  input wire logic [7:0] dmem_rdata_i,
  // Core state
  output logic [exec_pkg::FLAGS_W-1:0] flags_o,
  output logic [exec_pkg::PC_W-1:0] return_stack_top_o,
  output logic stack_full_o,
  output logic stack_empty_o,
  output logic quarter_one_o
);
  import exec_pkg::*;

  logic [QUARTERS-1:0] quarter;
  logic ext_en_q;
  logic [3:0] bank_select_reg_q;
  logic [FLAGS_W-1:0] flags_q;
  op_t op_q;
  op_t op_d;
  logic [7:0] file_q;
  logic access_q;
  logic [DADDR_W-1:0] addr_q;
  logic [7:0] operand_q;
  logic [FLAGS_W-1:0] neg_flags_q;
  logic [PC_W-1:0] push_pc_q;
  logic [STACK_PTR_W-1:0] depth;
  dmem_req_t dmem_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  function automatic logic is_nop(input logic [INSTR_W-1:0] w);
    return (w == OPC_NOP_ZERO) || (w[15:12] == OPC_NOP_HIGH);
  endfunction

  function automatic logic is_negate(input logic [INSTR_W-1:0] w);
    return w[15:OPC_NEGATE_LSB] == OPC_NEGATE;
  endfunction

  // Effective data address for a file operand
  function automatic logic [DADDR_W-1:0] file_addr(input logic [7:0] f, input logic a,
                                                    input logic ext, input logic [3:0] bank,
                                                    input logic [DADDR_W-1:0] base);
    logic [DADDR_W-1:0] r;
    r = '0;
    if (a) begin
      r = {bank, f};
    end else if (ext && f <= INDEXED_LIMIT) begin
      r = base + {4'h0, f};
    end else if (f < ACCESS_SPLIT) begin
      r = {ACCESS_LOW_BANK, f};
    end else begin
      r = {ACCESS_HIGH_BANK, f};
    end
    return r;
  endfunction

  quarter_gen u_quarter (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .quarter_o(quarter)
  );

  return_stack u_stack (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .push_i(op_q == OP_PUSH && quarter[1]),
    .pop_i(op_q == OP_POP && quarter[2]),
    .push_data_i(push_pc_q),
    .top_o(return_stack_top_o),
    .depth_o(depth),
    .full_o(stack_full_o),
    .empty_o(stack_empty_o)
  );

  // Decode
  always_comb begin
    op_d = OP_NONE;
    if (instr_valid_i) begin
      if (is_nop(instr_i)) begin
        op_d = OP_NOP;
      end else if (is_negate(instr_i)) begin
        op_d = OP_NEGATE;
      end else if (instr_i == OPC_POP) begin
        op_d = OP_POP;
      end else if (instr_i == OPC_PUSH) begin
        op_d = OP_PUSH;
      end else begin
        op_d = OP_NONE;
      end
    end
  end

  // Instruction latch, taken in the first quarter only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_q <= OP_NONE;
      file_q <= 8'h00;
      access_q <= 1'b0;
      push_pc_q <= '0;
    end else if (quarter[0]) begin
      op_q <= op_d;
      file_q <= instr_i[7:0];
      access_q <= instr_i[ACCESS_BIT];
      push_pc_q <= pc_i + PUSH_PC_STEP;
    end
  end

  // Address is fixed at decode so a bank write in mid-cycle cannot move the target
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q <= '0;
    end else if (quarter[0]) begin
      addr_q <= file_addr(instr_i[7:0], instr_i[ACCESS_BIT], ext_en_q, bank_select_reg_q, index_base_i);
    end
  end

  // Read in the second quarter, process in the third
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      operand_q <= 8'h00;
    end else if (op_q == OP_NEGATE && quarter[1]) begin
      operand_q <= dmem_rdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      neg_flags_q <= '0;
    end else if (op_q == OP_NEGATE && quarter[2]) begin
      neg_flags_q[FLAG_C] <= (operand_q == 8'h00);
      neg_flags_q[FLAG_DC] <= (operand_q[3:0] == 4'h0);
      neg_flags_q[FLAG_OV] <= (operand_q == 8'h80);
      neg_flags_q[FLAG_Z] <= (operand_q == 8'h00);
      neg_flags_q[FLAG_N] <= (operand_q != 8'h00) && !(operand_q[7] && operand_q[6:0] == 7'h00) ?
                             ~operand_q[7] : operand_q[7];
    end
  end

  // Flags change only on a negate write-back; pop, push and no-op leave them alone
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q <= FLAGS_RESET;
    end else if (op_q == OP_NEGATE && quarter[3]) begin
      flags_q <= neg_flags_q;
    end
  end

  // Data memory port, registered so it is glitch free
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dmem_q <= '0;
    end else begin
      dmem_q.rd <= (op_d == OP_NEGATE) && quarter[0];
      dmem_q.wr <= (op_q == OP_NEGATE) && quarter[2];
      dmem_q.wdata <= (op_q == OP_NEGATE && quarter[2]) ? (~operand_q + 8'h01) : 8'h00;
      if (quarter[0]) begin
        dmem_q.addr <= file_addr(instr_i[7:0], instr_i[ACCESS_BIT], ext_en_q, bank_select_reg_q,
                                 index_base_i);
      end else begin
        dmem_q.addr <= addr_q;
      end
    end
  end

  assign dmem_req_o = dmem_q;
  assign flags_o = flags_q;
  assign quarter_one_o = quarter[0];

  // Register bus: zero wait states, unmapped offsets answer with an error
  function automatic logic mapped(input logic [APB_AW-1:0] a);
    return (a == CTRL_OFS) || (a == BANK_OFS) || (a == FLAGS_OFS) || (a == STACK_OFS);
  endfunction

  logic apb_setup;
  logic apb_write;

  assign apb_setup = apb_req_i.psel && !apb_req_i.penable;
  assign apb_write = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && mapped(apb_req_i.paddr);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_en_q <= CTRL_RESET;
    end else if (apb_write && apb_req_i.paddr == CTRL_OFS) begin
      ext_en_q <= apb_req_i.pwdata[CTRL_EXT_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank_select_reg_q <= BANK_RESET;
    end else if (apb_write && apb_req_i.paddr == BANK_OFS) begin
      bank_select_reg_q <= apb_req_i.pwdata[3:0];
    end
  end

  // Read data is captured in the setup cycle and held through the access cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      pslverr_q <= !mapped(apb_req_i.paddr);
      case (apb_req_i.paddr)
        CTRL_OFS: prdata_q <= {31'h0, ext_en_q};
        BANK_OFS: prdata_q <= {28'h0, bank_select_reg_q};
        FLAGS_OFS: prdata_q <= {27'h0, flags_q};
        STACK_OFS: prdata_q <= {1'b0, stack_empty_o, stack_full_o, depth, 3'h0, return_stack_top_o};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // One driver for the whole response: registered fields plus a constant ready
  assign apb_rsp_o = '{prdata: prdata_q, pready: 1'b1, pslverr: pslverr_q};
endmodule

// ==== hw/quarter_gen.sv ====
// Purpose: Divides the clock into four quarter-phase enable pulses
// Assumes: One quarter per clock cycle
// Notes: Exactly one output pulses in every cycle after reset
`timescale 1ns/100ps
module quarter_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Phase pulses, bit 0 is the first quarter
  output logic [exec_pkg::QUARTERS-1:0] quarter_o
);
  import exec_pkg::*;

  logic [1:0] count_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_q + 2'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < QUARTERS; g++) begin : g_q
      assign quarter_o[g] = (count_q == 2'(g));
    end
  endgenerate
endmodule

// ==== hw/return_stack.sv ====
// Purpose: Hardware return stack held in flip-flops
// Assumes: Push and pop never arrive in the same cycle
// Notes: A push when full and a pop when empty are dropped and leave the stack intact
`timescale 1ns/100ps
module return_stack (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Operations
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [exec_pkg::PC_W-1:0] push_data_i,
  // State
  output logic [exec_pkg::PC_W-1:0] top_o,
  output logic [exec_pkg::STACK_PTR_W-1:0] depth_o,
  output logic full_o,
  output logic empty_o
);
  import exec_pkg::*;

  logic [PC_W-1:0] entry_q [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] ptr_q;

  assign full_o = (ptr_q == STACK_PTR_W'(STACK_DEPTH));
  assign empty_o = (ptr_q == '0);
  assign depth_o = ptr_q;
  // Entries below the pointer are never moved; the pointer alone makes the older one the top
  assign top_o = empty_o ? '0 : entry_q[ptr_q - 5'h1];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_q <= '0;
    end else if (push_i && !full_o) begin
      ptr_q <= ptr_q + 5'h1;
    end else if (pop_i && !empty_o) begin
      ptr_q <= ptr_q - 5'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : g_entry
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          entry_q[g] <= '0;
        end else if (push_i && !full_o && ptr_q == 5'(g)) begin
          entry_q[g] <= push_data_i;
        end
      end
    end
  endgenerate
endmodule

// ==== testbench/exec_chk_sva.sv ====
// Purpose: Port-level checker for the negate, no-op and stack-op block
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees only the top-level ports
`timescale 1ns/100ps
module exec_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register bus
  input wire exec_pkg::apb_req_t apb_req_i,
  input wire exec_pkg::apb_rsp_t apb_rsp_o,
  // Instruction stream
  input wire logic instr_valid_i,
  input wire logic [exec_pkg::INSTR_W-1:0] instr_i,
  input wire logic [exec_pkg::PC_W-1:0] pc_i,
  input wire logic [exec_pkg::DADDR_W-1:0] index_base_i,
  // Memory and core state
  input wire exec_pkg::dmem_req_t dmem_req_o,
  input wire logic [7:0] dmem_rdata_i,
  input wire logic [exec_pkg::FLAGS_W-1:0] flags_o,
  input wire logic [exec_pkg::PC_W-1:0] return_stack_top_o,
  input wire logic stack_full_o,
  input wire logic stack_empty_o,
  input wire logic quarter_one_o
);
  import exec_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  quarter_cycle_a: assert property (quarter_one_o |=> !quarter_one_o [*3] ##1 quarter_one_o)
    else $error("quarter phase sequence broken");
  read_cause_a: assert property (dmem_req_o.rd |->
    $past(quarter_one_o && instr_valid_i && instr_i[15:9] == OPC_NEGATE)) else $error("read without negate");
  write_back_a: assert property (dmem_req_o.rd |->
    ##2 dmem_req_o.wr && dmem_req_o.addr == $past(dmem_req_o.addr, 2)) else $error("write not to read address");
  negate_value_a: assert property (dmem_req_o.rd |->
    ##2 dmem_req_o.wdata == 8'(8'h00 - $past(dmem_rdata_i, 2))) else $error("result not negated");
  flags_hold_a: assert property (!dmem_req_o.wr |=> $stable(flags_o))
    else $error("flags changed without negate");
  zero_neg_a: assert property (dmem_req_o.wr |=> flags_o[FLAG_Z] == ($past(dmem_req_o.wdata) == 8'h00) &&
    flags_o[FLAG_N] == $past(dmem_req_o.wdata[7])) else $error("zero or negative flag wrong");
  ov_carry_a: assert property (dmem_req_o.wr |=> flags_o[FLAG_OV] == ($past(dmem_req_o.wdata) == 8'h80) &&
    flags_o[FLAG_C] == flags_o[FLAG_Z]) else $error("overflow or carry flag wrong");
  stack_timing_a: assert property ($changed(return_stack_top_o) |->
    $past(quarter_one_o, 2) || $past(quarter_one_o, 3)) else $error("stack top moved in wrong quarter");
  push_value_a: assert property (quarter_one_o && instr_valid_i && instr_i == OPC_PUSH && !stack_full_o |->
    ##2 return_stack_top_o == $past(pc_i, 2) + PUSH_PC_STEP) else $error("push value wrong");
endmodule

bind negate_nop_stack_ops_exec exec_chk exec_chk_inst (.clk_i, .reset_n_i, .apb_req_i, .apb_rsp_o,
  .instr_valid_i, .instr_i, .pc_i, .index_base_i, .dmem_req_o, .dmem_rdata_i, .flags_o,
  .return_stack_top_o, .stack_full_o, .stack_empty_o, .quarter_one_o);

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the negate, no-op and stack-op block
// Assumes: Memory read data held steady by the bench
// Notes: Instructions are aligned to the decode quarter
`timescale 1ns/100ps
module tb_top;
  import exec_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  apb_req_t apb_req_i = '0;
  apb_rsp_t apb_rsp_o;
  logic instr_valid_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic [PC_W-1:0] pc_i = '0;
  logic [DADDR_W-1:0] index_base_i = '0;
  dmem_req_t dmem_req_o;
  logic [7:0] dmem_rdata_i = 8'h00;
  logic [FLAGS_W-1:0] flags_o;
  logic [PC_W-1:0] return_stack_top_o;
  logic stack_full_o;
  logic stack_empty_o;
  logic quarter_one_o;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] rd_v;
  logic err_v;

  negate_nop_stack_ops_exec negate_nop_stack_ops_exec_inst (.clk_i, .reset_n_i, .apb_req_i, .apb_rsp_o,
    .instr_valid_i, .instr_i, .pc_i, .index_base_i, .dmem_req_o, .dmem_rdata_i, .flags_o,
    .return_stack_top_o, .stack_full_o, .stack_empty_o, .quarter_one_o);

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb_req_i <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_i);
    apb_req_i.penable <= 1'b1;
    do @(posedge clk_i); while (apb_rsp_o.pready !== 1'b1);
    rd_v = apb_rsp_o.prdata;
    err_v = apb_rsp_o.pslverr;
    apb_req_i <= '0;
  endtask

  // Waits a whole cycle for the next decode quarter, so drives land on its opening edge
  task automatic issue(input logic [15:0] w, input logic [PC_W-1:0] p);
    @(negedge clk_i);
    while (quarter_one_o !== 1'b1) @(negedge clk_i);
    repeat (4) @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    pc_i <= p;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
  endtask

  task automatic neg(input logic a, input logic [7:0] f, input logic [7:0] v, input logic [11:0] ea);
    logic [7:0] r;
    r = 8'h00 - v;
    dmem_rdata_i <= v;
    issue({OPC_NEGATE, a, f}, 21'h0);
    #1;
    chk("rd", dmem_req_o.rd, 1);
    chk("rd_addr", dmem_req_o.addr, ea);
    repeat (2) @(posedge clk_i);
    #1;
    chk("wr", dmem_req_o.wr, 1);
    chk("wr_addr", dmem_req_o.addr, ea);
    chk("wdata", dmem_req_o.wdata, r);
    @(posedge clk_i);
    #1;
    chk("flags", flags_o, {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00});
  endtask

  task automatic stk(input logic [15:0] w, input logic [PC_W-1:0] p, input logic [PC_W-1:0] e3,
    input logic [PC_W-1:0] e4);
    logic [FLAGS_W-1:0] f0;
    f0 = flags_o;
    issue(w, p);
    @(posedge clk_i);
    #1;
    chk("top_q3", return_stack_top_o, e3);
    @(posedge clk_i);
    #1;
    chk("top_q4", return_stack_top_o, e4);
    chk("flags_kept", flags_o, f0);
  endtask

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    apb(1'b1, BANK_OFS, 32'h5);
    apb(1'b0, BANK_OFS, 32'h0);
    chk("bank", rd_v, 32'h5);
    neg(1'b0, 8'h20, 8'h3a, 12'h020);
    neg(1'b0, 8'h90, 8'h00, 12'hf90);
    neg(1'b1, 8'h33, 8'h80, 12'h533);
    apb(1'b0, FLAGS_OFS, 32'h0);
    chk("flags_reg", rd_v, 32'h1a);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", err_v, 1);
    apb(1'b1, CTRL_OFS, 32'h1);
    index_base_i <= 12'h100;
    neg(1'b0, 8'h5f, 8'h01, 12'h15f);
    neg(1'b0, 8'h60, 8'h10, 12'h060);
    neg(1'b1, 8'h05, 8'hff, 12'h505);
    stk(OPC_PUSH, 21'h124, 21'h126, 21'h126);
    stk(OPC_PUSH, 21'h200, 21'h202, 21'h202);
    stk(OPC_NOP_ZERO, 21'h300, 21'h202, 21'h202);
    stk(16'hf0a5, 21'h304, 21'h202, 21'h202);
    stk(OPC_POP, 21'h0, 21'h202, 21'h126);
    stk(OPC_POP, 21'h0, 21'h126, 21'h0);
    chk("empty", stack_empty_o, 1);
    for (int i = 0; i < 31; i++) begin
      stk(OPC_PUSH, 21'(i * 4), 21'(i * 4 + 2), 21'(i * 4 + 2));
    end
    chk("full", stack_full_o, 1);
    stk(OPC_PUSH, 21'h400, 21'h07a, 21'h07a);
    stk(OPC_POP, 21'h0, 21'h07a, 21'h076);
    end_sim();
  end
endmodule
